// *** core/tpg_cfg.svh ***
// Offsets, field positions, reset values, pattern words and timing counts of the test-pattern block.
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH

// ----------------------------------------------------------------------
// Register indexes: the byte address of each register is four times its index.
// ----------------------------------------------------------------------
`define TPG_IDX_TEST_MODE   6'h0D
`define TPG_IDX_FORMAT      6'h14
`define TPG_IDX_UP1_LOW     6'h19
`define TPG_IDX_UP1_HIGH    6'h1A
`define TPG_IDX_UP2_LOW     6'h1B
`define TPG_IDX_UP2_HIGH    6'h1C
`define TPG_IDX_FILTER      6'h2B
`define TPG_IDX_IMPEDANCE   6'h2C

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define TPG_BIT_TWOS        0
`define TPG_BIT_TUNE        6
`define TPG_BIT_IMPEDANCE   0
`define TPG_RST_BYTE        8'h00
`define TPG_RST_MODE        4'h0

// ----------------------------------------------------------------------
// Fixed pattern words.
// ----------------------------------------------------------------------
`define TPG_W_MIDSCALE      12'h800
`define TPG_W_ONES          12'hFFF
`define TPG_W_ZEROS         12'h000
`define TPG_W_CHECK_A       12'hAAA
`define TPG_W_CHECK_B       12'h555
`define TPG_W_SYNC          12'h03F
`define TPG_W_ONE_BIT       12'h800
`define TPG_W_MIXED         12'hA33

// ----------------------------------------------------------------------
// Pseudo-noise seeds and timing counts.
// ----------------------------------------------------------------------
`define TPG_PN_LONG_SEED    23'h7FFFFF
`define TPG_PN_SHORT_SEED   9'h1FF
`define TPG_TUNE_CYCLES     1000

// ----------------------------------------------------------------------
// Bus answers.
// ----------------------------------------------------------------------
`define TPG_RESP_OKAY       2'h0
`define TPG_RESP_SLVERR     2'h2

`endif

// *** core/tpg_pkg.sv ***
// Types shared by the test-pattern block: the mode enumeration and the state record.
package tpg_pkg;

	// Test-mode codes; the implicit encoding 0 to 12 is the selector code itself.
	typedef enum logic [3:0] {
		TM_OFF, TM_MIDSCALE, TM_FULL_POS, TM_FULL_NEG, TM_CHECKER, TM_PN_LONG,
		TM_PN_SHORT, TM_WORD_TOGGLE, TM_USER, TM_BIT_TOGGLE, TM_SYNC, TM_ONE_BIT,
		TM_MIXED
	} test_mode_t;

	// Every flip-flop of the block lives in this one record.
	typedef struct packed {
		logic        awready;    // Write address ready.
		logic        aw_full;    // A write address is held.
		logic [5:0]  aw_idx;     // Held register index.
		logic        wready;     // Write data ready.
		logic        w_full;     // Write data is held.
		logic [7:0]  w_byte;     // Held low byte of write data.
		logic        w_lane0;    // Byte lane 0 was enabled.
		logic        bvalid;     // Write response valid.
		logic [1:0]  bresp;      // Write response code.
		logic        arready;    // Read address ready.
		logic        rvalid;     // Read data valid.
		logic [31:0] rdata;      // Read data.
		logic [1:0]  rresp;      // Read response code.
		logic [3:0]  mode_reg;   // Selector code as written by software.
		logic [3:0]  mode_act;   // Selector code in force on the output.
		logic        twos;       // Twos complement output format.
		logic [7:0]  up1_low;    // User pattern one, low byte.
		logic [7:0]  up1_high;   // User pattern one, high byte.
		logic [7:0]  up2_low;    // User pattern two, low byte.
		logic [7:0]  up2_high;   // User pattern two, high byte.
		logic        tune_busy;  // Filter tuning in progress.
		logic [15:0] tune_cnt;   // Cycles spent tuning.
		logic        tune_start; // One-cycle tuning start pulse.
		logic        imp_high;   // High input impedance selected.
		logic        phase;      // Zero for word one, one for word two.
		logic [22:0] pn_long;    // Long pseudo-noise register.
		logic [8:0]  pn_short;   // Short pseudo-noise register.
		logic [11:0] out_data;   // Output sample word.
		logic        out_valid;  // Output sample strobe.
	} state_t;

endpackage : tpg_pkg

// *** core/adc_output_test_pattern_gen.sv ***
// Output test-pattern generator for a 12-bit converter port, with its AXI4-Lite registers.
// What this block does
// - Code 0000 passes conversion results through.
// - Code 0001 drives midscale word.
// - Code 0010 drives positive full scale.
// - Code 0011 drives negative full scale.
// - Code 0100 alternates checkerboard words.
// - Code 0101 drives long pseudo-noise.
// - Code 0110 drives short pseudo-noise.
// - Code 0111 alternates all ones, zeros.
// - Code 1000 word one from pattern one.
// - User word two from pattern two.
// - Code 1001 drives alternating-bit word.
// - Code 1010 drives sync word.
// - Code 1011 drives only MSB set.
// - Code 1100 drives mixed word; above undefined.
// - Format applies only to listed patterns.
// - Tune bit starts tuning, clears itself.
// - Format bit selects offset or twos.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "tpg_cfg.svh"

module adc_output_test_pattern_gen #(
	parameter int TUNE_CYCLES = `TPG_TUNE_CYCLES // Length of a filter tuning run.
) (
	input  wire logic        mclk,          // 25 MHz clock.
	input  wire logic        reset_n,       // Synchronous reset, active low.
	input  wire logic [7:0]  s_axi_awaddr,  // Write byte address.
	input  wire logic        s_axi_awvalid, // Write address valid.
	output logic             s_axi_awready, // Write address ready.
	input  wire logic [31:0] s_axi_wdata,   // Write data.
	input  wire logic [3:0]  s_axi_wstrb,   // Write byte lanes.
	input  wire logic        s_axi_wvalid,  // Write data valid.
	output logic             s_axi_wready,  // Write data ready.
	output logic [1:0]       s_axi_bresp,   // Write response.
	output logic             s_axi_bvalid,  // Write response valid.
	input  wire logic        s_axi_bready,  // Write response ready.
	input  wire logic [7:0]  s_axi_araddr,  // Read byte address.
	input  wire logic        s_axi_arvalid, // Read address valid.
	output logic             s_axi_arready, // Read address ready.
	output logic [31:0]      s_axi_rdata,   // Read data.
	output logic [1:0]       s_axi_rresp,   // Read response.
	output logic             s_axi_rvalid,  // Read data valid.
	input  wire logic        s_axi_rready,  // Read data ready.
	input  wire logic        sample_valid,  // One-cycle strobe per converter sample.
	input  wire logic [11:0] sample_data,   // Offset-binary conversion result.
	output logic [11:0]      out_data,      // Output word toward capture logic.
	output logic             out_valid,     // One-cycle strobe with each output word.
	output logic             tune_start,    // One-cycle pulse that starts filter tuning.
	output logic             tune_busy,     // High while filter tuning runs.
	output logic             imp_high       // High input impedance selected.
);

	// ----------------------------------------------------------------------
	// Constants and helper functions.
	// ----------------------------------------------------------------------
	localparam logic [15:0] TUNE_LAST = 16'(TUNE_CYCLES - 1); // Last tuning cycle.

	// Applies the output format: twos complement is offset binary with the MSB inverted.
	function automatic logic [11:0] fmt_word(input logic [11:0] w, input logic twos);
		fmt_word = twos ? {~w[11], w[10:0]} : w;
	endfunction : fmt_word

	// Answers whether a register index is mapped; shared by the read and write paths.
	function automatic logic is_mapped(input logic [5:0] idx);
		is_mapped = (idx == `TPG_IDX_TEST_MODE) || (idx == `TPG_IDX_FORMAT)
			|| (idx == `TPG_IDX_UP1_LOW) || (idx == `TPG_IDX_UP1_HIGH)
			|| (idx == `TPG_IDX_UP2_LOW) || (idx == `TPG_IDX_UP2_HIGH)
			|| (idx == `TPG_IDX_FILTER) || (idx == `TPG_IDX_IMPEDANCE);
	endfunction : is_mapped

	// Builds the 12-bit output word for a mode; user words keep the top 12 of 16 bits.
	function automatic logic [11:0] pattern(input tpg_pkg::state_t s, input logic [11:0] din);
		logic [11:0] w;
		w = din;
		case (tpg_pkg::test_mode_t'(s.mode_act))
			tpg_pkg::TM_MIDSCALE:    w = fmt_word(`TPG_W_MIDSCALE, s.twos);
			tpg_pkg::TM_FULL_POS:    w = fmt_word(`TPG_W_ONES, s.twos);
			tpg_pkg::TM_FULL_NEG:    w = fmt_word(`TPG_W_ZEROS, s.twos);
			tpg_pkg::TM_CHECKER:     w = s.phase ? `TPG_W_CHECK_B : `TPG_W_CHECK_A;
			tpg_pkg::TM_PN_LONG:     w = fmt_word(s.pn_long[22:11], s.twos);
			tpg_pkg::TM_PN_SHORT:    w = fmt_word({s.pn_short, s.pn_short[8:6]}, s.twos);
			tpg_pkg::TM_WORD_TOGGLE: w = s.phase ? `TPG_W_ZEROS : `TPG_W_ONES;
			tpg_pkg::TM_USER: begin
				// Word one from pattern one, word two from pattern two; no format applied.
				if (s.phase) begin
					w = {s.up2_high, s.up2_low[7:4]};
				end else begin
					w = {s.up1_high, s.up1_low[7:4]};
				end
			end
			tpg_pkg::TM_BIT_TOGGLE:  w = `TPG_W_CHECK_A;
			tpg_pkg::TM_SYNC:        w = `TPG_W_SYNC;
			tpg_pkg::TM_ONE_BIT:     w = `TPG_W_ONE_BIT;
			tpg_pkg::TM_MIXED:       w = `TPG_W_MIXED;
			// Off and the undefined codes above 1100 pass converted data, formatted.
			default:                 w = fmt_word(din, s.twos);
		endcase
		pattern = w;
	endfunction : pattern

	// ----------------------------------------------------------------------
	// State registers.
	// ----------------------------------------------------------------------
	tpg_pkg::state_t st_q; // Registered state.
	tpg_pkg::state_t st_d; // Next state.
	logic [5:0]      rd_idx; // Read register index.

	assign rd_idx = s_axi_araddr[7:2];

	// ----------------------------------------------------------------------
	// Next-state logic: bus slave, register effects and the output path.
	// ----------------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.tune_start = 1'b0;
		st_d.out_valid  = 1'b0;

		// A taken write response frees the write path.
		if (st_q.bvalid && s_axi_bready) begin
			st_d.bvalid = 1'b0;
		end

		// Address and data both held: perform the write and raise the response.
		if (st_q.aw_full && st_q.w_full && !st_q.bvalid) begin
			st_d.aw_full = 1'b0;
			st_d.w_full  = 1'b0;
			st_d.bvalid  = 1'b1;
			st_d.bresp   = is_mapped(st_q.aw_idx) ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
			// Only byte lane 0 carries register bits; a write without it changes nothing.
			if (st_q.w_lane0) begin
				if (st_q.aw_idx == `TPG_IDX_TEST_MODE) begin
					st_d.mode_reg = st_q.w_byte[3:0];
				end else if (st_q.aw_idx == `TPG_IDX_FORMAT) begin
					st_d.twos = st_q.w_byte[`TPG_BIT_TWOS];
				end else if (st_q.aw_idx == `TPG_IDX_UP1_LOW) begin
					st_d.up1_low = st_q.w_byte;
				end else if (st_q.aw_idx == `TPG_IDX_UP1_HIGH) begin
					st_d.up1_high = st_q.w_byte;
				end else if (st_q.aw_idx == `TPG_IDX_UP2_LOW) begin
					st_d.up2_low = st_q.w_byte;
				end else if (st_q.aw_idx == `TPG_IDX_UP2_HIGH) begin
					st_d.up2_high = st_q.w_byte;
				end else if (st_q.aw_idx == `TPG_IDX_FILTER) begin
					// A new start wins over completion in the same cycle and restarts the run.
					if (st_q.w_byte[`TPG_BIT_TUNE]) begin
						st_d.tune_busy  = 1'b1;
						st_d.tune_cnt   = 16'h0000;
						st_d.tune_start = 1'b1;
					end
				end else if (st_q.aw_idx == `TPG_IDX_IMPEDANCE) begin
					st_d.imp_high = st_q.w_byte[`TPG_BIT_IMPEDANCE];
				end
			end
		end

		// Take a write address and write data, each on its own handshake.
		if (s_axi_awvalid && st_q.awready) begin
			st_d.aw_full = 1'b1;
			st_d.aw_idx  = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && st_q.wready) begin
			st_d.w_full  = 1'b1;
			st_d.w_byte  = s_axi_wdata[7:0];
			st_d.w_lane0 = s_axi_wstrb[0];
		end

		// Tuning runs a fixed count and then drops the bit by itself.
		if (st_q.tune_busy && !st_d.tune_start) begin
			if (st_q.tune_cnt == TUNE_LAST) begin
				st_d.tune_busy = 1'b0;
			end else begin
				st_d.tune_cnt = st_q.tune_cnt + 16'h0001;
			end
		end

		// Read path: one read at a time, answered the cycle after the address.
		if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_q.arready) begin
			st_d.rvalid = 1'b1;
			st_d.rresp  = is_mapped(rd_idx) ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
			st_d.rdata  = 32'h00000000;
			if (rd_idx == `TPG_IDX_TEST_MODE) begin
				st_d.rdata[3:0] = st_q.mode_reg;
			end else if (rd_idx == `TPG_IDX_FORMAT) begin
				st_d.rdata[`TPG_BIT_TWOS] = st_q.twos;
			end else if (rd_idx == `TPG_IDX_UP1_LOW) begin
				st_d.rdata[7:0] = st_q.up1_low;
			end else if (rd_idx == `TPG_IDX_UP1_HIGH) begin
				st_d.rdata[7:0] = st_q.up1_high;
			end else if (rd_idx == `TPG_IDX_UP2_LOW) begin
				st_d.rdata[7:0] = st_q.up2_low;
			end else if (rd_idx == `TPG_IDX_UP2_HIGH) begin
				st_d.rdata[7:0] = st_q.up2_high;
			end else if (rd_idx == `TPG_IDX_FILTER) begin
				st_d.rdata[`TPG_BIT_TUNE] = st_q.tune_busy;
			end else if (rd_idx == `TPG_IDX_IMPEDANCE) begin
				st_d.rdata[`TPG_BIT_IMPEDANCE] = st_q.imp_high;
			end
		end

		// Output path: each sample strobe emits one word and advances the sequences.
		if (sample_valid) begin
			st_d.out_valid = 1'b1;
			if (st_q.mode_reg != st_q.mode_act) begin
				// A new code switches on this sample, restarting at word one and the seed.
				st_d.mode_act = st_q.mode_reg;
				st_d.phase    = 1'b0;
				st_d.pn_long  = `TPG_PN_LONG_SEED;
				st_d.pn_short = `TPG_PN_SHORT_SEED;
				st_d.out_data = pattern(st_d, sample_data);
				st_d.phase    = 1'b1;
			end else begin
				st_d.out_data = pattern(st_q, sample_data);
				st_d.phase    = ~st_q.phase;
			end
			// Long sequence x^23+x^18+1, short sequence x^9+x^5+1, one step per sample.
			st_d.pn_long  = {st_d.pn_long[21:0], st_d.pn_long[22] ^ st_d.pn_long[17]};
			st_d.pn_short = {st_d.pn_short[7:0], st_d.pn_short[8] ^ st_d.pn_short[4]};
		end

		// Ready flags follow what is held, so each handshake waits for room.
		st_d.awready = !st_d.aw_full && !st_d.bvalid;
		st_d.wready  = !st_d.w_full && !st_d.bvalid;
		st_d.arready = !st_d.rvalid;
	end

	// ----------------------------------------------------------------------
	// State register with synchronous reset; every register resets to zero except the two noise registers, which load their seeds.
	// ----------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			st_q          <= '0;
			st_q.mode_reg <= `TPG_RST_MODE;
			st_q.mode_act <= `TPG_RST_MODE;
			st_q.up2_low  <= `TPG_RST_BYTE;
			st_q.up2_high <= `TPG_RST_BYTE;
			st_q.pn_long  <= `TPG_PN_LONG_SEED;
			st_q.pn_short <= `TPG_PN_SHORT_SEED;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------------
	// Outputs, each taken straight from the state register.
	// ----------------------------------------------------------------------
	assign s_axi_awready = st_q.awready;
	assign s_axi_wready  = st_q.wready;
	assign s_axi_bvalid  = st_q.bvalid;
	assign s_axi_bresp   = st_q.bresp;
	assign s_axi_arready = st_q.arready;
	assign s_axi_rvalid  = st_q.rvalid;
	assign s_axi_rdata   = st_q.rdata;
	assign s_axi_rresp   = st_q.rresp;
	assign out_data      = st_q.out_data;
	assign out_valid     = st_q.out_valid;
	assign tune_start    = st_q.tune_start;
	assign tune_busy     = st_q.tune_busy;
	assign imp_high      = st_q.imp_high;

	// ----------------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// A sample taken while a settled mode is in force.
	sequence s_steady(logic [3:0] m);
		sample_valid && st_q.mode_act == m && st_q.mode_reg == m;
	endsequence

	property p_off_pass;
		s_steady(4'h0) |=> out_valid && out_data == fmt_word($past(sample_data), $past(st_q.twos));
	endproperty
	a_off_pass: assert property (p_off_pass) else $error("off mode lost data");

	property p_midscale;
		s_steady(4'h1) |=> out_data == fmt_word(12'h800, $past(st_q.twos));
	endproperty
	a_midscale: assert property (p_midscale) else $error("midscale word wrong");

	property p_full_pos;
		s_steady(4'h2) |=> out_data == fmt_word(12'hFFF, $past(st_q.twos));
	endproperty
	a_full_pos: assert property (p_full_pos) else $error("positive full scale wrong");

	property p_full_neg;
		s_steady(4'h3) |=> out_data == fmt_word(12'h000, $past(st_q.twos));
	endproperty
	a_full_neg: assert property (p_full_neg) else $error("negative full scale wrong");

	property p_checker;
		s_steady(4'h4) ##1 s_steady(4'h4) |=> out_data == ~$past(out_data);
	endproperty
	a_checker: assert property (p_checker) else $error("checkerboard did not alternate");

	property p_word_toggle;
		s_steady(4'h7) |=> out_data == 12'hFFF || out_data == 12'h000;
	endproperty
	a_word_toggle: assert property (p_word_toggle) else $error("word toggle wrong");

	property p_fixed_words;
		s_steady(4'hA) |=> out_data == 12'h03F;
	endproperty
	a_fixed_words: assert property (p_fixed_words) else $error("sync word wrong");

	property p_mixed;
		s_steady(4'hC) |=> out_data == 12'hA33;
	endproperty
	a_mixed: assert property (p_mixed) else $error("mixed word wrong");

	property p_bit_toggle;
		s_steady(4'h9) |=> out_data == 12'hAAA;
	endproperty
	a_bit_toggle: assert property (p_bit_toggle) else $error("bit toggle word wrong");

	property p_one_bit;
		s_steady(4'hB) |=> out_data == 12'h800;
	endproperty
	a_one_bit: assert property (p_one_bit) else $error("one-bit-high word wrong");

	// Both seeds are all ones, so the first noise word after entry is all ones below the MSB.
	// Only the MSB depends on the format, which keeps this check format-blind.
	property p_pn_reseed;
		sample_valid && st_q.mode_reg inside {4'h5, 4'h6} && st_q.mode_reg != st_q.mode_act
			|=> out_data[10:0] == 11'h7FF;
	endproperty
	a_pn_reseed: assert property (p_pn_reseed) else $error("noise did not restart from seed");

	property p_tune_pulse;
		tune_start |-> tune_busy ##1 !tune_start;
	endproperty
	a_tune_pulse: assert property (p_tune_pulse) else $error("tuning start pulse wrong");

	property p_restart;
		sample_valid && st_q.mode_reg == 4'h4 && st_q.mode_act != 4'h4 |=> out_data == 12'hAAA;
	endproperty
	a_restart: assert property (p_restart) else $error("new mode did not start at word one");

	property p_tune_clears;
		$rose(tune_busy) |-> tune_busy [*2] ##[0:1000] (!tune_busy || $rose(tune_start));
	endproperty
	a_tune_clears: assert property (p_tune_clears) else $error("tuning bit stuck");

endmodule : adc_output_test_pattern_gen

// *** tb/capture_model.sv ***
// Capture-side model: registers each output word as downstream logic would.
`timescale 1ns/1ps
module capture_model (
	input  wire logic        mclk,      // Sample clock.
	input  wire logic        reset_n,   // Synchronous reset, active low.
	input  wire logic [11:0] out_data,  // Word from the generator.
	input  wire logic        out_valid, // Strobe from the generator.
	output logic      [11:0] cap_word,  // Captured word.
	output logic             cap_valid  // One-cycle strobe per captured word.
);
	// Capture only on the strobe; the word between strobes is never trusted.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			cap_valid <= 1'b0;
			cap_word  <= 12'h000;
		end else begin
			cap_valid <= out_valid;
			if (out_valid) cap_word <= out_data;
		end
	end
endmodule : capture_model

// *** tb/tb_top.sv ***
// Self-checking bench for the output test-pattern generator and its register port.
`timescale 1ns/1ps
module tb_top;
	// ----------------------------------------------------------------
	// Signals and model state.
	// ----------------------------------------------------------------
	logic        mclk = 1'b0;                           // Bench clock.
	logic        reset_n = 1'b0;                        // Active-low reset.
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00; // Bus addresses.
	logic [31:0] s_axi_wdata = 32'h0;                   // Write data.
	logic [3:0]  s_axi_wstrb = 4'hF;                    // All lanes written.
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0; // Write side.
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0; // Read side.
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid; // Readies.
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;         // Responses.
	logic [31:0] s_axi_rdata, rdv, seed;                // Read data and seed.
	logic        sample_valid = 1'b0;                   // Sample strobe.
	logic [11:0] sample_data = 12'h000, out_data, cap_word; // Stream words.
	logic        out_valid, cap_valid, tune_start, tune_busy, imp_high; // Status outputs.
	logic [3:0]  md;                                    // Mode the model follows.
	logic        ph, twos;                              // Word phase and format.
	logic [22:0] pl;                                    // Long noise register.
	logic [8:0]  ps;                                    // Short noise register.
	logic [7:0]  u1l, u1h, u2l, u2h;                    // User pattern bytes.
	logic [11:0] exp_q [$];                             // Expected words, oldest first.
	int          err_total = 0, tests_run = 0, cyc = 0, starts = 0; // Counters.

	adc_output_test_pattern_gen #(.TUNE_CYCLES(40)) uut (
		.mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_valid, .sample_data,
		.out_data, .out_valid, .tune_start, .tune_busy, .imp_high);
	capture_model cap (.mclk, .reset_n, .out_data, .out_valid, .cap_word, .cap_valid);

	// Half-period toggle gives 40 ns.
	always #20 mclk = ~mclk;

	// ----------------------------------------------------------------
	// Tasks.
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks=%0d mismatches=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_sim

	// Handshakes are judged at the falling edge, where registered outputs are settled.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		b = 1'b0;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (!b) begin
			@(negedge mclk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = (s_axi_bvalid === 1'b1);
			rsp = s_axi_bresp;
			@(posedge mclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		// One edge passes so that a following call never drives bready twice in one step.
		@(posedge mclk);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic ar, r;
		r = 1'b0;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		while (!r) begin
			@(negedge mclk);
			ar = s_axi_arvalid & s_axi_arready;
			r = (s_axi_rvalid === 1'b1);
			rdv = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge mclk);
			if (ar) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		// One edge passes so that a following call never drives rready twice in one step.
		@(posedge mclk);
	endtask : rd

	// A new code restarts alternation at word one and reseeds both noise registers.
	task automatic set_mode(input logic [3:0] m);
		wr(8'h34, {28'h0, m});
		md = m;
		ph = 1'b0;
		pl = 23'h7FFFFF;
		ps = 9'h1FF;
	endtask : set_mode

	task automatic model(input logic [11:0] s, output logic [11:0] e);
		logic fmt;
		fmt = !(md inside {4'h4, [4'h7:4'hC]});
		case (md)
			4'h1: e = 12'h800;
			4'h2: e = 12'hFFF;
			4'h3: e = 12'h000;
			4'h4: e = ph ? 12'h555 : 12'hAAA;
			4'h5: e = pl[22:11];
			4'h6: e = {ps, ps[8:6]};
			4'h7: e = ph ? 12'h000 : 12'hFFF;
			4'h8: e = ph ? {u2h, u2l[7:4]} : {u1h, u1l[7:4]};
			4'h9: e = 12'hAAA;
			4'hA: e = 12'h03F;
			4'hB: e = 12'h800;
			4'hC: e = 12'hA33;
			default: e = s;
		endcase
		if (fmt && twos) e[11] = ~e[11];
		ph = ~ph;
		pl = {pl[21:0], pl[22] ^ pl[17]};
		ps = {ps[7:0], ps[8] ^ ps[4]};
	endtask : model

	// Back-to-back random samples; each expected word is noted as it is driven.
	task automatic send(input int cnt);
		logic [11:0] s, e;
		for (int i = 0; i < cnt; i++) begin
			s = 12'($urandom);
			model(s, e);
			exp_q.push_back(e);
			sample_data  <= s;
			sample_valid <= 1'b1;
			@(posedge mclk);
		end
		sample_valid <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask : send

	// ----------------------------------------------------------------
	// Watchers: stream compare, tuning pulses and the hang limit.
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		if (cap_valid === 1'b1) begin
			if (exp_q.size() == 0) chk({20'h0, cap_word}, 32'hFFFFFFFF);
			else chk({20'h0, cap_word}, {20'h0, exp_q.pop_front()});
		end
		if (tune_start === 1'b1) starts++;
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, cyc, 0);
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		seed = $urandom(28);
		twos = 1'b0;
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		rd(8'h6C);
		chk(rdv, 32'h0);
		rd(8'h70);
		chk(rdv, 32'h0);
		rd(8'hAC);
		chk(rdv, 32'h0);
		rd(8'hB0);
		chk(rdv, 32'h0);
		rd(8'hFC);
		chk({30'h0, rsp}, 32'h2);
		wr(8'hFC, 32'h5A);
		chk({30'h0, rsp}, 32'h2);
		$display("reset values and unmapped place done");
		u1l = 8'($urandom);
		u1h = 8'($urandom);
		u2l = 8'($urandom);
		u2h = 8'($urandom);
		wr(8'h64, {24'h0, u1l});
		wr(8'h68, {24'h0, u1h});
		wr(8'h6C, {24'h0, u2l});
		wr(8'h70, {24'h0, u2h});
		chk({30'h0, rsp}, 32'h0);
		rd(8'h70);
		chk(rdv, {24'h0, u2h});
		// Odd sample counts make a restart at word one visible on each change into code 4, 7 or 8, the alternating modes.
		for (int tw = 0; tw < 2; tw++) begin
			wr(8'h50, tw);
			twos = tw[0];
			for (int m = 0; m < 14; m++) begin
				set_mode(m[3:0]);
				send(3);
			end
		end
		$display("pattern modes in both formats done");
		wr(8'hAC, 32'h40);
		rd(8'hAC);
		chk(rdv, 32'h40);
		while (tune_busy !== 1'b0) @(posedge mclk);
		rd(8'hAC);
		chk(rdv, 32'h0);
		chk(starts, 1);
		$display("filter tuning done");
		wr(8'hB0, 32'h1);
		chk({31'h0, imp_high}, 32'h1);
		rd(8'hB0);
		chk(rdv, 32'h1);
		$display("impedance select done");
		end_sim();
	end
endmodule : tb_top
